// file: rtl/lcms_pkg.sv
// Constants and types for the control mode select front end
package lcms_pkg;

  // Control port select codes
  localparam logic [1:0] LCMS_CPS_HW = 2'h0;
  localparam logic [1:0] LCMS_CPS_SERIAL = 2'h1;
  localparam logic [1:0] LCMS_CPS_PAR_AS = 2'h2;
  localparam logic [1:0] LCMS_CPS_PAR_LE = 2'h3;

  // Line path mode select codes
  localparam logic [1:0] LCMS_LPM_SR_ZS = 2'h0;
  localparam logic [1:0] LCMS_LPM_SR_AMI = 2'h1;
  localparam logic [1:0] LCMS_LPM_DR_CDR = 2'h2;
  localparam logic [1:0] LCMS_LPM_SLICER = 2'h3;

  // Cycles from pin to registered output
  localparam int LCMS_DECODE_LAT = 3;

  typedef enum logic [3:0] {
    LCMS_MODE_HW = 4'h1,
    LCMS_MODE_SERIAL = 4'h2,
    LCMS_MODE_PAR_AS = 4'h4,
    LCMS_MODE_PAR_LE = 4'h8
  } lcms_mode_t;

  // One-hot bit positions of the mode
  localparam int LCMS_BIT_HW = 0;
  localparam int LCMS_BIT_SERIAL = 1;
  localparam int LCMS_BIT_PAR_AS = 2;
  localparam int LCMS_BIT_PAR_LE = 3;

  typedef struct packed {
    logic [3:0] waveform_template_sel;
    logic driver_tristate;
    logic [1:0] loopback_sel;
    logic [1:0] test_sequence_sel;
    logic [1:0] jitter_atten_place;
    logic monitor_gain_sel;
    logic termination_sel;
    logic adaptive_gain_sel;
    logic receiver_power_down;
  } lcms_hw_strap_t;

  typedef struct packed {
    logic single_rail;
    logic ami_coding;
    logic timing_recovery;
    logic slicer;
  } lcms_line_cfg_t;

  typedef struct packed {
    logic [1:0] ctrl_port_sel;
    logic chip_sel_n;
    logic shift_clock_edge_sel;
    logic rx_clock_edge_sel;
    logic [1:0] line_path_mode_sel;
    lcms_hw_strap_t strap;
  } lcms_pins_t;

  localparam int LCMS_PINS_W = 22;

  // Values after reset
  localparam lcms_mode_t LCMS_MODE_RST = LCMS_MODE_HW;
  localparam lcms_hw_strap_t LCMS_STRAP_RST = 15'h0000;
  localparam lcms_line_cfg_t LCMS_LINE_RST = 4'hA;
  localparam logic [LCMS_PINS_W-1:0] LCMS_PINS_RST = 22'h080000;

endpackage

// file: rtl/lcms_sync2.sv
// Two-stage synchroniser for a bundle of static levels
`timescale 1ns/100ps
module lcms_sync2
  import lcms_pkg::*;
#(
  parameter int W = LCMS_PINS_W,
  parameter logic [W-1:0] RST_VAL = '0
)
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_sync;

  always_comb
  begin
    nxt_meta = d_i;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end
    else
    begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign q_o = sync_ff;

endmodule // lcms_sync2

// file: rtl/lcms_mode_select.sv
// Control mode select and hardware strap decode
`timescale 1ns/100ps

// How it works
// - Select code 01 enables the serial port with its chip select, shift clock, edge select, data and interrupt.
// - In serial mode the shift clock edge select level picks the shift clock edge used for output data.
// - Code 10 enables the strobe/read-write parallel port and 11 the latch/separate-strobe parallel port.
// - In hardware mode all configuration comes from the dedicated strap pins.
// - Code 00 selects hardware mode with no processor port active.
// - In hardware mode a low receive clock edge select means rising edge, high means falling edge.
// - A port is only accessed while chip select is low; activity with chip select high is ignored.
// - Line path code 00 gives single rail with zero substitution, 01 single rail with AMI.
// - Line path code 10 gives dual rail with timing recovery, 11 slicer mode without it.
// - Line path pins act only in hardware mode; software modes take register settings.
module lcms_mode_select
  import lcms_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [1:0] ctrl_port_sel_i,
  input wire logic chip_sel_n_i,
  input wire logic shift_clock_edge_sel_i,
  input wire logic rx_clock_edge_sel_i,
  input wire logic [1:0] line_path_mode_sel_i,
  input wire lcms_hw_strap_t hw_strap_i,
  input wire lcms_line_cfg_t sw_line_cfg_i,
  input wire logic sw_rx_edge_fall_i,
  output logic hw_mode_o,
  output logic serial_port_en_o,
  output logic par_as_rw_en_o,
  output logic par_latch_en_o,
  output logic serial_out_fall_o,
  output logic port_access_o,
  output logic rx_clk_fall_edge_o,
  output lcms_line_cfg_t line_cfg_o,
  output lcms_hw_strap_t hw_strap_o
);

  lcms_pins_t pins_raw;
  lcms_pins_t pins_s;
  logic [LCMS_PINS_W-1:0] pins_q;

  lcms_mode_t mode_ff;
  lcms_mode_t nxt_mode;
  logic serial_out_fall_ff;
  logic nxt_serial_out_fall;
  logic port_access_ff;
  logic nxt_port_access;
  logic rx_fall_ff;
  logic nxt_rx_fall;
  lcms_line_cfg_t line_cfg_ff;
  lcms_line_cfg_t nxt_line_cfg;
  lcms_hw_strap_t strap_ff;
  lcms_hw_strap_t nxt_strap;
  logic sel_hw;

  function automatic lcms_line_cfg_t lcms_decode_line(input logic [1:0] code);
    lcms_line_cfg_t cfg;
    cfg = LCMS_LINE_RST;
    case (code)
      LCMS_LPM_SR_ZS: cfg = 4'hA;
      LCMS_LPM_SR_AMI: cfg = 4'hE;
      LCMS_LPM_DR_CDR: cfg = 4'h2;
      LCMS_LPM_SLICER: cfg = 4'h1;
      default: cfg = LCMS_LINE_RST;
    endcase
    return cfg;
  endfunction

  always_comb
  begin
    pins_raw.ctrl_port_sel = ctrl_port_sel_i;
    pins_raw.chip_sel_n = chip_sel_n_i;
    pins_raw.shift_clock_edge_sel = shift_clock_edge_sel_i;
    pins_raw.rx_clock_edge_sel = rx_clock_edge_sel_i;
    pins_raw.line_path_mode_sel = line_path_mode_sel_i;
    pins_raw.strap = hw_strap_i;
  end

  lcms_sync2 #(
    .W(LCMS_PINS_W),
    .RST_VAL(LCMS_PINS_RST)
  ) u_pin_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .d_i(pins_raw),
    .q_o(pins_q)
  );

  assign pins_s = lcms_pins_t'(pins_q);
  assign sel_hw = (pins_s.ctrl_port_sel == LCMS_CPS_HW);

  always_comb
  begin
    case (pins_s.ctrl_port_sel)
      LCMS_CPS_HW: nxt_mode = LCMS_MODE_HW;
      LCMS_CPS_SERIAL: nxt_mode = LCMS_MODE_SERIAL;
      LCMS_CPS_PAR_AS: nxt_mode = LCMS_MODE_PAR_AS;
      LCMS_CPS_PAR_LE: nxt_mode = LCMS_MODE_PAR_LE;
      default: nxt_mode = LCMS_MODE_HW;
    endcase
    nxt_serial_out_fall = (pins_s.ctrl_port_sel == LCMS_CPS_SERIAL) & pins_s.shift_clock_edge_sel;
    nxt_port_access = ~sel_hw & ~pins_s.chip_sel_n;
    nxt_rx_fall = sel_hw ? pins_s.rx_clock_edge_sel : sw_rx_edge_fall_i;
    nxt_line_cfg = sel_hw ? lcms_decode_line(pins_s.line_path_mode_sel) : sw_line_cfg_i;
    nxt_strap = sel_hw ? pins_s.strap : LCMS_STRAP_RST;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      mode_ff <= LCMS_MODE_RST;
      serial_out_fall_ff <= 1'b0;
      port_access_ff <= 1'b0;
      rx_fall_ff <= 1'b0;
      line_cfg_ff <= LCMS_LINE_RST;
      strap_ff <= LCMS_STRAP_RST;
    end
    else
    begin
      mode_ff <= nxt_mode;
      serial_out_fall_ff <= nxt_serial_out_fall;
      port_access_ff <= nxt_port_access;
      rx_fall_ff <= nxt_rx_fall;
      line_cfg_ff <= nxt_line_cfg;
      strap_ff <= nxt_strap;
    end
  end

  assign hw_mode_o = mode_ff[LCMS_BIT_HW];
  assign serial_port_en_o = mode_ff[LCMS_BIT_SERIAL];
  assign par_as_rw_en_o = mode_ff[LCMS_BIT_PAR_AS];
  assign par_latch_en_o = mode_ff[LCMS_BIT_PAR_LE];
  assign serial_out_fall_o = serial_out_fall_ff;
  assign port_access_o = port_access_ff;
  assign rx_clk_fall_edge_o = rx_fall_ff;
  assign line_cfg_o = line_cfg_ff;
  assign hw_strap_o = strap_ff;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence sel_held(logic [1:0] code);
    (ctrl_port_sel_i == code)[*3];
  endsequence

  sequence hw_lpm_held(logic [1:0] code);
    (ctrl_port_sel_i == LCMS_CPS_HW && line_path_mode_sel_i == code)[*3];
  endsequence

  sequence ser_fall_held;
    (ctrl_port_sel_i == LCMS_CPS_SERIAL && shift_clock_edge_sel_i)[*3];
  endsequence

  sequence hw_rx_held(logic level);
    (ctrl_port_sel_i == LCMS_CPS_HW && rx_clock_edge_sel_i == level)[*3];
  endsequence

  sequence sw_held;
    (ctrl_port_sel_i != LCMS_CPS_HW)[*3];
  endsequence

  sequence sw_cs_low_held;
    (ctrl_port_sel_i != LCMS_CPS_HW && !chip_sel_n_i)[*3];
  endsequence

  serial_sel_a: assert property (sel_held(LCMS_CPS_SERIAL) |=> serial_port_en_o && !hw_mode_o)
    else $error("serial port not enabled for code 01");
  par_sel_a: assert property (sel_held(LCMS_CPS_PAR_AS) |=> par_as_rw_en_o && !par_latch_en_o)
    else $error("strobe parallel port not enabled for code 10");
  latch_sel_a: assert property (sel_held(LCMS_CPS_PAR_LE) |=> par_latch_en_o && !par_as_rw_en_o)
    else $error("latch parallel port not enabled for code 11");
  hw_sel_a: assert property (sel_held(LCMS_CPS_HW) |=> hw_mode_o && !port_access_o)
    else $error("hardware mode not entered for code 00");
  one_port_a: assert property ($onehot({hw_mode_o, serial_port_en_o, par_as_rw_en_o, par_latch_en_o}))
    else $error("port enables not one-hot");
  sdo_edge_a: assert property (ser_fall_held |=> serial_out_fall_o)
    else $error("shift clock edge select not followed");
  cs_gate_a: assert property ((chip_sel_n_i)[*3] |=> !port_access_o)
    else $error("port access with chip select high");
  cs_open_a: assert property (sw_cs_low_held |=> port_access_o)
    else $error("no port access with chip select low");
  rx_edge_a: assert property (hw_rx_held(1'b1) |=> rx_clk_fall_edge_o[*2])
    else $error("receive clock edge select not followed");
  rx_rise_a: assert property (hw_rx_held(1'b0) |=> !rx_clk_fall_edge_o)
    else $error("receive clock rising edge not selected");
  ami_path_a: assert property (hw_lpm_held(LCMS_LPM_SR_AMI) |=> line_cfg_o == 4'hE)
    else $error("single rail AMI decode wrong");
  zs_path_a: assert property (hw_lpm_held(LCMS_LPM_SR_ZS) |=> line_cfg_o == 4'hA)
    else $error("single rail zero substitution decode wrong");
  slicer_path_a: assert property (hw_lpm_held(LCMS_LPM_SLICER) |=> line_cfg_o == 4'h1)
    else $error("slicer decode wrong");
  cdr_path_a: assert property (hw_lpm_held(LCMS_LPM_DR_CDR) |=> line_cfg_o == 4'h2)
    else $error("dual rail recovery decode wrong");
  sw_line_a: assert property (sw_held ##0 $stable(sw_line_cfg_i) |=> line_cfg_o == $past(sw_line_cfg_i))
    else $error("software line setting not used");
  strap_a: assert property (sel_held(LCMS_CPS_HW) |=> hw_strap_o == $past(hw_strap_i, 3))
    else $error("hardware strap not applied");

endmodule // lcms_mode_select

// file: test/lcms_host_model.sv
// Board strap and host model driving the pin bundle
`timescale 1ns/100ps
module lcms_host_model
  import lcms_pkg::*;
(
  input wire lcms_pins_t req_i,
  output lcms_pins_t pins_o
);
  always_comb
  begin
    pins_o = req_i;
    if (req_i.ctrl_port_sel != LCMS_CPS_HW)
    begin
      pins_o.rx_clock_edge_sel = 1'b0;
    end
  end
endmodule // lcms_host_model

// file: test/lineif_control_mode_select_test.sv
// Self-checking bench for the control mode select front end
`timescale 1ns/100ps
module lineif_control_mode_select_test;
  import lcms_pkg::*;
  localparam logic [3:0] LINE_TBL [4] = '{4'hA, 4'hE, 4'h2, 4'h1};
  localparam logic [25:0] RST_EXP = {1'b1, 6'h00, 4'hA, 15'h0000};
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  lcms_pins_t req = '0;
  lcms_pins_t pins;
  lcms_line_cfg_t sw_line = '0;
  logic sw_rx = 1'b0;
  logic hw_mode, ser_en, as_en, le_en, out_fall, access, rx_fall;
  lcms_line_cfg_t line_cfg;
  lcms_hw_strap_t strap;
  logic [25:0] exp_q [$];
  logic [25:0] exp_now;
  logic [31:0] lfsr = 32'h00013CF8;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  event sample_ev;

  lcms_host_model u_host (.req_i(req), .pins_o(pins));
  lcms_mode_select u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ctrl_port_sel_i(pins.ctrl_port_sel),
    .chip_sel_n_i(pins.chip_sel_n), .shift_clock_edge_sel_i(pins.shift_clock_edge_sel),
    .rx_clock_edge_sel_i(pins.rx_clock_edge_sel), .line_path_mode_sel_i(pins.line_path_mode_sel),
    .hw_strap_i(pins.strap), .sw_line_cfg_i(sw_line), .sw_rx_edge_fall_i(sw_rx), .hw_mode_o(hw_mode),
    .serial_port_en_o(ser_en), .par_as_rw_en_o(as_en), .par_latch_en_o(le_en), .serial_out_fall_o(out_fall),
    .port_access_o(access), .rx_clk_fall_edge_o(rx_fall), .line_cfg_o(line_cfg), .hw_strap_o(strap));

  always #2.5 ref_clk_i = ~ref_clk_i;

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Expected outputs for a settled pin set
  function automatic logic [25:0] expect_out(input lcms_pins_t p, input lcms_line_cfg_t sl, input logic sr);
    logic hw;
    hw = (p.ctrl_port_sel == LCMS_CPS_HW);
    return {hw, p.ctrl_port_sel == LCMS_CPS_SERIAL, p.ctrl_port_sel == LCMS_CPS_PAR_AS,
      p.ctrl_port_sel == LCMS_CPS_PAR_LE, p.ctrl_port_sel == LCMS_CPS_SERIAL && p.shift_clock_edge_sel,
      !hw && !p.chip_sel_n, hw ? p.rx_clock_edge_sel : sr,
      hw ? LINE_TBL[p.line_path_mode_sel] : sl, hw ? p.strap : 15'h0000};
  endfunction

  task automatic check(input string name, input logic [25:0] seen, input logic [25:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, want, seen);
    end
  endtask

  task automatic close_out;
    if (bad_count == 0 && samples_checked > 0)
    begin
      $display("STATUS OK");
    end
    else
    begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Random pins, then note the result due three edges on
  task automatic apply(input logic [1:0] cps, input logic [1:0] lpm);
    lcms_pins_t p;
    repeat (8) lfsr = lfsr_next(lfsr);
    p = lfsr[21:0];
    p.ctrl_port_sel = cps;
    p.line_path_mode_sel = lpm;
    req = p;
    sw_line = lfsr[25:22];
    sw_rx = lfsr[26];
    repeat (LCMS_DECODE_LAT) @(negedge ref_clk_i);
    exp_q.push_back(expect_out(p, sw_line, sw_rx));
    -> sample_ev;
  endtask

  task automatic note_reset;
    exp_q.push_back(RST_EXP);
    -> sample_ev;
  endtask

  always
  begin
    @(sample_ev);
    exp_now = exp_q.pop_front();
    check("port enables", 26'({hw_mode, ser_en, as_en, le_en}), 26'(exp_now[25:22]));
    check("shift edge", 26'(out_fall), 26'(exp_now[21]));
    check("port access", 26'(access), 26'(exp_now[20]));
    check("rx edge", 26'(rx_fall), 26'(exp_now[19]));
    check("line cfg", 26'(line_cfg), 26'(exp_now[18:15]));
    check("straps", 26'(strap), 26'(exp_now[14:0]));
  end

  always @(posedge ref_clk_i)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      bad_count++;
      close_out();
    end
  end

  initial
  begin
    repeat (6) @(negedge ref_clk_i);
    note_reset();
    rst_i = 1'b0;
    for (int i = 0; i < 32; i++)
    begin
      apply(i[1:0], i[3:2]);
    end
    rst_i = 1'b1;
    @(negedge ref_clk_i);
    note_reset();
    rst_i = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      apply(i[3:2], ~i[1:0]);
    end
    @(negedge ref_clk_i);
    close_out();
  end
endmodule // lineif_control_mode_select_test
